//--- hdl/bcm_master.sv
`timescale 1ns/1ps
// What this block does
// [RULE_01] Hold atomic_hold across locked cycles
// [RULE_02] Slave drives no_cache per answered cycle
// [RULE_03] Assert burst_request with full_cycle_strobe at address
// [RULE_04] Slave answers burst_ack with slave_select
// [RULE_05] Missing request or ack means single cycle
// [RULE_06] After first ack drop strobes, request only
// [RULE_07] Slave keeps slave_select through burst
// [RULE_08] Short cycle drives new A7-A2 only
// [RULE_09] Reassert burst_request to start short cycle
// [RULE_10] Read strobes with request, write strobes after
// [RULE_11] Slave gives data then data_ack
// [RULE_12] Closing master drops all strobes together
// [RULE_13] Sample burst_ack at burst_request falling edge
// [RULE_14] Slave negates burst_ack one cycle early
// [RULE_15] After ack loss finish one more, end
// [RULE_16] Never request bursts not supported
// [RULE_17] Burst support optional for slaves
// [RULE_18] Slave releases select and data at end
// [RULE_19] Slave combines latched page with low address
module bcm_master
  #(parameter logic BURST_CAPABLE = 1'b1)
(
  input  wire logic                           clk,
  input  wire logic                           resetn,
  input  wire logic                           req_valid,
  output logic                                req_ready,
  input  wire bcm_pkg::bcm_req_s              req,
  input  wire logic                           req_last,
  output logic                                rsp_valid,
  output bcm_pkg::bcm_rsp_s                   rsp,
  output logic                                busy,
  output logic [bcm_pkg::ADDR_W-1:0]          addr_o,
  output logic                                addr_oe,
  output logic [bcm_pkg::DATA_W-1:0]          data_o,
  output logic                                data_oe,
  input  wire logic [bcm_pkg::DATA_W-1:0]     data_i,
  output logic                                write_o,
  output logic                                full_cycle_strobe,
  output logic                                data_phase_enable,
  output logic [bcm_pkg::STRB_W-1:0]          data_strobes,
  output logic                                burst_request,
  output logic                                atomic_hold,
  input  wire logic                           slave_select,
  input  wire logic                           burst_ack,
  input  wire logic                           no_cache,
  input  wire logic                           data_ack
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Bit order: select, burst ack, no cache, data ack
  logic [3:0]                  sync1_q;
  logic [3:0]                  sync2_q;
  logic [bcm_pkg::DATA_W-1:0]  dsync1_q;
  logic [bcm_pkg::DATA_W-1:0]  dsync2_q;
  wire                         sel_s  = sync2_q[3];
  wire                         mack_s = sync2_q[2];
  wire                         inh_s  = sync2_q[1];
  wire                         dack_s = sync2_q[0];

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1_q  <= 4'h0;
      sync2_q  <= 4'h0;
      dsync1_q <= 32'h0;
      dsync2_q <= 32'h0;
    end
    else
    begin
      sync1_q  <= {slave_select, burst_ack, no_cache, data_ack};
      sync2_q  <= sync1_q;
      dsync1_q <= data_i;
      dsync2_q <= dsync1_q;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  bcm_pkg::bcm_state_e                state_q;
  bcm_pkg::bcm_state_e                state_d;
  logic [bcm_pkg::CNT_W-1:0]          cnt_q;
  logic                               in_burst_q;
  logic                               cont_ok_q;
  logic                               stop_q;
  logic                               lock_q;
  bcm_pkg::bcm_req_s                  cur_q;
  logic                               want_mt_q;

  wire idle_st  = (state_q == bcm_pkg::ST_IDLE);
  wire take     = req_valid && req_ready;
  wire want_mt  = BURST_CAPABLE && req.burst; // [RULE_16]
  wire setup_ok = (cnt_q == '0);
  wire last_sc  = stop_q || !cont_ok_q;
  // Next short cycle needs a queued request that fits the same page and burst
  // Ack loss still grants this one; the end is decided at data_ack
  wire next_ok  = req_valid && req.burst && !stop_q
                  && (req.addr[bcm_pkg::ADDR_W-1:bcm_pkg::LOW_ADDR_HI+1]
                      == cur_q.addr[bcm_pkg::ADDR_W-1:bcm_pkg::LOW_ADDR_HI+1]); // [RULE_08]

  // Taken while idle, or in the gap only on the edge that leaves it, so the request is never lost
  assign req_ready = idle_st || (state_q == bcm_pkg::ST_SHORT_GAP && !dack_s && next_ok);
  assign busy      = !idle_st;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      bcm_pkg::ST_IDLE:       if (req_valid) state_d = bcm_pkg::ST_ADDR;
      bcm_pkg::ST_ADDR:       if (setup_ok) state_d = bcm_pkg::ST_SELECT;
      bcm_pkg::ST_SELECT:     if (sel_s) state_d = bcm_pkg::ST_DATA;
      bcm_pkg::ST_DATA:       if (setup_ok) state_d = bcm_pkg::ST_WAIT_ACK;
      bcm_pkg::ST_WAIT_ACK:
        if (dack_s)
          state_d = (in_burst_q && !last_sc) ? bcm_pkg::ST_SHORT_GAP : bcm_pkg::ST_END;
      bcm_pkg::ST_SHORT_GAP:
        if (!dack_s)
          state_d = next_ok ? bcm_pkg::ST_SHORT_ADDR : bcm_pkg::ST_END;
      bcm_pkg::ST_SHORT_ADDR: if (setup_ok) state_d = bcm_pkg::ST_DATA;
      bcm_pkg::ST_END:        if (!sel_s) state_d = bcm_pkg::ST_IDLE; // [RULE_18]
      default:                state_d = bcm_pkg::ST_IDLE;
    endcase
  end

  wire enter_setup = (state_d != state_q)
                     && (state_d == bcm_pkg::ST_ADDR || state_d == bcm_pkg::ST_SHORT_ADDR);
  wire enter_data  = (state_d != state_q) && (state_d == bcm_pkg::ST_DATA);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q    <= bcm_pkg::ST_IDLE;
      cnt_q      <= '0;
      in_burst_q <= 1'b0;
      cont_ok_q  <= 1'b0;
      stop_q     <= 1'b0;
      lock_q     <= 1'b0;
      cur_q      <= '0;
    end
    else
    begin
      state_q <= state_d;
      if (enter_setup)
        cnt_q <= bcm_pkg::CNT_W'(bcm_pkg::ADDR_SETUP_CYC);
      else if (enter_data)
        cnt_q <= bcm_pkg::CNT_W'(bcm_pkg::DATA_SETUP_CYC);
      else if (cnt_q != '0)
        cnt_q <= cnt_q - 1'b1;
      if (take)
      begin
        cur_q  <= req;
        stop_q <= req_last;
      end
      if (take && idle_st)
        lock_q <= req.lock; // [RULE_01]
      else if (idle_st && !req_valid)
        lock_q <= 1'b0;
      if (state_q == bcm_pkg::ST_SELECT && sel_s)
      begin
        in_burst_q <= want_mt_q && mack_s; // [RULE_05]
        cont_ok_q  <= mack_s;
      end
      // Ack level sampled where burst_request falls
      if (state_q == bcm_pkg::ST_WAIT_ACK && dack_s)
        cont_ok_q <= mack_s; // [RULE_13] [RULE_15]
      if (state_d == bcm_pkg::ST_IDLE)
        in_burst_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      want_mt_q <= 1'b0;
    else if (take && idle_st)
      want_mt_q <= want_mt;
  end

  // ****************************************
  // Pin drive
  // ****************************************
  wire st_addr  = (state_q == bcm_pkg::ST_ADDR);
  wire st_data  = (state_q == bcm_pkg::ST_DATA) || (state_q == bcm_pkg::ST_WAIT_ACK);
  wire st_sa    = (state_q == bcm_pkg::ST_SHORT_ADDR);
  wire st_gap   = (state_q == bcm_pkg::ST_SHORT_GAP);
  wire in_cycle = !idle_st && (state_q != bcm_pkg::ST_END);
  // Write strobes wait a data setup after the short request
  wire wr_late  = cur_q.write && (state_q == bcm_pkg::ST_DATA) && !setup_ok && in_burst_q;

  assign full_cycle_strobe = in_cycle && !(st_addr && !setup_ok && cnt_q
                             == bcm_pkg::CNT_W'(bcm_pkg::ADDR_SETUP_CYC)); // [RULE_12]
  assign addr_oe           = st_addr || st_sa || (state_q == bcm_pkg::ST_SELECT && !sel_s);
  assign addr_o            = cur_q.addr; // [RULE_08]
  assign write_o           = cur_q.write;
  assign data_phase_enable = st_data || st_gap || st_sa; // [RULE_06]
  assign data_strobes      = (st_data && !wr_late) ? cur_q.strobes : 4'h0; // [RULE_10]
  assign data_oe           = cur_q.write && (st_data || st_sa);
  assign data_o            = cur_q.wdata;
  // Request during address phase and while each short cycle runs
  assign burst_request     = (want_mt_q && (st_addr || state_q == bcm_pkg::ST_SELECT))
                             || (in_burst_q && (st_sa || st_data)); // [RULE_03] [RULE_09]
  assign atomic_hold       = lock_q && !(idle_st && !req_valid); // [RULE_01]

  // ****************************************
  // Response
  // ****************************************
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rsp_valid <= 1'b0;
      rsp       <= '0;
    end
    else
    begin
      rsp_valid <= (state_q == bcm_pkg::ST_WAIT_ACK) && dack_s;
      if ((state_q == bcm_pkg::ST_WAIT_ACK) && dack_s)
      begin
        rsp.rdata       <= dsync2_q;
        rsp.no_cache    <= inh_s;
        rsp.burst_taken <= in_burst_q;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_req_no_burst: assert property (@(posedge clk) disable iff (!resetn) // [RULE_16]
    burst_request |-> BURST_CAPABLE && cur_q.burst)
    else $error("burst request without capability");
  chk_short_keep_fcs: assert property (@(posedge clk) disable iff (!resetn) // [RULE_06]
    st_gap |-> full_cycle_strobe && data_phase_enable && data_strobes == 4'h0
      && !burst_request) else $error("short gap signals wrong");
  chk_single_no_gap: assert property (@(posedge clk) disable iff (!resetn) // [RULE_05]
    (state_q == bcm_pkg::ST_WAIT_ACK && dack_s && !in_burst_q)
      |=> state_q == bcm_pkg::ST_END) else $error("single cycle not closed");
  chk_ack_loss_end: assert property (@(posedge clk) disable iff (!resetn) // [RULE_15]
    (state_q == bcm_pkg::ST_WAIT_ACK && dack_s && !cont_ok_q)
      |=> state_q == bcm_pkg::ST_END) else $error("burst after ack loss");
  chk_end_release: assert property (@(posedge clk) disable iff (!resetn) // [RULE_12]
    state_q == bcm_pkg::ST_END |-> !full_cycle_strobe && !data_phase_enable
      && !burst_request) else $error("strobes held at end");
  chk_lock_cover: assert property (@(posedge clk) disable iff (!resetn) // [RULE_01]
    ($rose(full_cycle_strobe) && cur_q.lock) |-> atomic_hold)
    else $error("lock dropped in cycle");
  chk_page_kept: assert property (@(posedge clk) disable iff (!resetn) // [RULE_08]
    $rose(st_sa) |-> $stable(cur_q.addr[bcm_pkg::ADDR_W-1:bcm_pkg::LOW_ADDR_HI+1]))
    else $error("page changed");
  chk_rsp_after_ack: assert property (@(posedge clk) disable iff (!resetn) // [RULE_11]
    rsp_valid |-> $past(dack_s) && $past(data_strobes != 4'h0))
    else $error("response without data ack");

  cov_single: cover property (@(posedge clk) disable iff (!resetn)
    state_q == bcm_pkg::ST_WAIT_ACK && dack_s && !in_burst_q);
  cov_short: cover property (@(posedge clk) disable iff (!resetn) st_sa);
  cov_ack_loss: cover property (@(posedge clk) disable iff (!resetn)
    in_burst_q && !cont_ok_q);
  cov_locked: cover property (@(posedge clk) disable iff (!resetn) atomic_hold && busy);

endmodule

//--- hdl/bcm_pkg.sv
package bcm_pkg;

  // ****************************************
  // Bus widths and field layout
  // ****************************************
  localparam int ADDR_W      = 32;
  localparam int DATA_W      = 32;
  localparam int LOW_ADDR_HI = 7;
  localparam int LOW_ADDR_LO = 2;
  localparam int LOW_ADDR_W  = LOW_ADDR_HI - LOW_ADDR_LO + 1;
  localparam int PAGE_BYTES  = 256;
  localparam int STRB_W      = 4;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS  = 10;
  localparam int ADDR_SETUP_NS  = 20;
  localparam int ADDR_SETUP_CYC = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DATA_SETUP_NS  = 10;
  localparam int DATA_SETUP_CYC = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W          = 4;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [STRB_W-1:0] strobes;
    logic              write;
    logic              lock;
    logic              burst;
  } bcm_req_s;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic              no_cache;
    logic              burst_taken;
  } bcm_rsp_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_SELECT,
    ST_DATA,
    ST_WAIT_ACK,
    ST_SHORT_GAP,
    ST_SHORT_ADDR,
    ST_END
  } bcm_state_e;

endpackage

//--- verif/bcm_master_tb_top.sv
`timescale 1ns/1ps
module bcm_master_tb_top;
  logic              clk, resetn, req_valid, req_last, burst_en, nc_en, exp_lock, fcs_d;
  logic [3:0]        limit, strb;
  bcm_pkg::bcm_req_s req;
  bcm_pkg::bcm_rsp_s rsp;
  logic              req_ready, rsp_valid, addr_oe, data_oe, write_o, fcs, dpe, breq, lock;
  logic [31:0]       addr_o, data_o, data_i;
  logic              sel, back, nc, dack, busy;
  int                mismatches, tests_run, cycles, fulls, bad;

  bcm_master #(.BURST_CAPABLE(1'b1)) i_dut
  (
    .clk              (clk),
    .resetn           (resetn),
    .req_valid        (req_valid),
    .req_ready        (req_ready),
    .req              (req),
    .req_last         (req_last),
    .rsp_valid        (rsp_valid),
    .rsp              (rsp),
    .busy             (busy),
    .addr_o           (addr_o),
    .addr_oe          (addr_oe),
    .data_o           (data_o),
    .data_oe          (data_oe),
    .data_i           (data_i),
    .write_o          (write_o),
    .full_cycle_strobe(fcs),
    .data_phase_enable(dpe),
    .data_strobes     (strb),
    .burst_request    (breq),
    .atomic_hold      (lock),
    .slave_select     (sel),
    .burst_ack        (back),
    .no_cache         (nc),
    .data_ack         (dack)
  );

  bcm_slave_model i_slave
  (
    .clk     (clk),
    .resetn  (resetn),
    .addr    (addr_o),
    .wdata   (data_o),
    .write   (write_o),
    .fcs     (fcs),
    .dpe     (dpe),
    .strb    (strb),
    .breq    (breq),
    .burst_en(burst_en),
    .nc_en   (nc_en),
    .limit   (limit),
    .sel     (sel),
    .back    (back),
    .nc      (nc),
    .dack    (dack),
    .rdata   (data_i)
  );

  // ****************************************
  // Clock, watchdog and bus monitor
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask

  task automatic results;
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    fcs_d <= fcs;
    if (fcs && !fcs_d)
    begin
      fulls++;
      check({31'h0, breq}, {31'h0, req.burst}, "burst request at address");
    end
    if ((fcs && exp_lock && !lock) || (strb != 4'h0 && !dpe) || (fcs && !busy)
        || (fcs && !fcs_d && !addr_oe) || (data_oe && !write_o))
      bad++;
    if (cycles > 20000)
    begin
      mismatches++;
      results();
    end
  end

  // ****************************************
  // Transfer driver and scenarios
  // ****************************************
  task automatic xfer(input logic [7:0] off, input logic w, lk, bu, la);
    int n;
    @(negedge clk);
    req = '{addr:32'h20000300 | off, wdata:{24'ha5a5a5, off}, strobes:4'hf,
            write:w, lock:lk, burst:bu};
    req_last  = la;
    req_valid = 1'b1;
    n = 0;
    while (!req_ready && n < 2000)
    begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    req_valid = 1'b0;
    while (!rsp_valid && n < 4000)
    begin
      @(negedge clk);
      n++;
    end
    check({31'h0, n < 4000}, 32'h1, "transfer hung");
    if (!w)
      check(rsp.rdata, {24'ha5a5a5, off}, "read data");
  endtask

  task automatic t_single;
    exp_lock = 1'b1;
    fulls = 0;
    xfer(8'h10, 1'b1, 1'b1, 1'b0, 1'b1);
    xfer(8'h10, 1'b0, 1'b1, 1'b0, 1'b1);
    exp_lock = 1'b0;
    check({31'h0, rsp.burst_taken}, 32'h0, "plain cycle taken as burst");
    check({31'h0, rsp.no_cache}, 32'h0, "no_cache without cause");
    check(fulls, 2, "single cycles");
    nc_en = 1'b1;
    xfer(8'h10, 1'b0, 1'b0, 1'b0, 1'b1);
    check({31'h0, rsp.no_cache}, 32'h1, "no_cache lost");
    nc_en = 1'b0;
  endtask

  task automatic t_burst;
    logic [7:0] off [4];
    off = '{8'h00, 8'h04, 8'hfc, 8'h04};
    fulls = 0;
    for (int i = 0; i < 4; i++)
      xfer(off[i], i < 3, 1'b0, 1'b1, i == 3);
    check({31'h0, rsp.burst_taken}, 32'h1, "burst refused");
    check(fulls, 1, "burst split");
    for (int i = 0; i < 3; i++)
      xfer(off[2 - i], 1'b0, 1'b0, 1'b1, i == 2);
    check(fulls, 2, "burst end");
  endtask

  task automatic t_limit;
    limit = 4'h2;
    fulls = 0;
    for (int i = 0; i < 4; i++)
      xfer(8'h04 * (i % 2), 1'b0, 1'b0, 1'b1, i == 3);
    check(fulls, 2, "slave limit ignored");
    limit = 4'h8;
    burst_en = 1'b0;
    fulls = 0;
    xfer(8'h20, 1'b1, 1'b0, 1'b1, 1'b0);
    xfer(8'h24, 1'b1, 1'b0, 1'b1, 1'b1);
    check({31'h0, rsp.burst_taken}, 32'h0, "burst without ack");
    check(fulls, 2, "no-ack burst");
    check(bad, 0, "strobe or lock fault");
  endtask

  initial
  begin
    resetn = 1'b0;
    req_valid = 1'b0;
    req = '0;
    req_last = 1'b0;
    burst_en = 1'b1;
    nc_en = 1'b0;
    exp_lock = 1'b0;
    limit = 4'h8;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    t_single;
    t_burst;
    t_limit;
    results;
  end
endmodule

//--- verif/bcm_slave_model.sv
`timescale 1ns/1ps
module bcm_slave_model
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        write,
  input  wire logic        fcs,
  input  wire logic        dpe,
  input  wire logic [3:0]  strb,
  input  wire logic        breq,
  input  wire logic        burst_en,
  input  wire logic        nc_en,
  input  wire logic [3:0]  limit,
  output logic             sel,
  output logic             back,
  output logic             nc,
  output logic             dack,
  output logic [31:0]      rdata
);
  logic [31:0] mem [0:63];
  logic [23:0] page_q;
  logic [3:0]  cnt_q;
  logic        fcs_q;
  logic        rdy_q;

  // ****************************************
  // Slave side of full and short cycles
  // ****************************************
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      {sel, back, nc, dack, fcs_q, rdy_q, cnt_q} <= '0;
      rdata <= 32'h5a5a5a5a;
    end
    else
    begin
      fcs_q <= fcs;
      if (fcs && !fcs_q)
      begin
        page_q <= addr[31:8];
        sel    <= 1'b1;
        back   <= burst_en && breq && limit > 4'h1;
        nc     <= nc_en;
        cnt_q  <= 4'h0;
      end
      else if (!fcs)
      begin
        {sel, back, nc, dack, rdy_q} <= '0;
        rdata <= ~rdata;
      end
      else if (dpe && strb != 4'h0 && !dack)
      begin
        // Data is set up a cycle ahead of the acknowledge
        if (!rdy_q)
        begin
          // Writes off the latched page are dropped, so read-back exposes them
          if (write && addr[31:8] == page_q)
            mem[addr[7:2]] <= wdata;
          else if (!write)
            rdata <= mem[addr[7:2]];
        end
        else
        begin
          dack  <= 1'b1;
          cnt_q <= cnt_q + 4'h1;
          if ({1'b0, cnt_q} + 5'h2 >= {1'b0, limit})
            back <= 1'b0;
        end
        rdy_q <= !rdy_q;
      end
      else if (strb == 4'h0 && dack)
      begin
        dack  <= 1'b0;
        rdata <= ~rdata;
      end
    end
  end
endmodule
